// >>> verilog/mlb_regs.svh
// register offsets, field positions, reset values and region sizes of the loop branch unit
`ifndef MLB_REGS_SVH
`define MLB_REGS_SVH

`define MLB_OFF_LOOP_COUNT 5'h00
`define MLB_OFF_EPILOG_COUNT 5'h04
`define MLB_OFF_ROT_BASES 5'h08
`define MLB_OFF_PREV_BASES 5'h0c
`define MLB_OFF_GR_ROT_SIZE 5'h10
`define MLB_OFF_PREFETCH 5'h14
`define MLB_OFF_STATUS 5'h18

`define MLB_GR_LSB 0
`define MLB_FR_LSB 8
`define MLB_PR_LSB 16
`define MLB_MANY_LSB 8

`define MLB_FR_ROT_SIZE 7'h60
`define MLB_PR_ROT_SIZE 7'h30
`define MLB_GR_SIZE_RST 7'h00
`define MLB_FEW_LINES_RST 4'h2
`define MLB_MANY_LINES_RST 4'h8
`define MLB_BASES_RST 20'h0_0000
`define MLB_UNMAPPED_READ 32'h0000_0000

`endif

// >>> verilog/mlb_pkg.sv
// types shared by the loop branch unit and its hint decoder
`default_nettype none
package mlb_pkg;

  typedef enum logic [7:0] {
    MLB_OP_CLEAR_ALL = 8'h01,
    MLB_OP_CLEAR_PRED = 8'h02,
    MLB_OP_CALL = 8'h04,
    MLB_OP_RETURN = 8'h08,
    MLB_OP_COUNTED_TOP = 8'h10,
    MLB_OP_COUNTED_EXIT = 8'h20,
    MLB_OP_WHILE_TOP = 8'h40,
    MLB_OP_WHILE_EXIT = 8'h80
  } mlb_op_type;

  typedef enum logic [3:0] {
    MLB_STATIC_NOT_TAKEN = 4'h1,
    MLB_STATIC_TAKEN = 4'h2,
    MLB_DYNAMIC_NOT_TAKEN = 4'h4,
    MLB_DYNAMIC_TAKEN = 4'h8
  } mlb_strategy_type;

  typedef struct packed {
    logic [6:0] gr;
    logic [6:0] fr;
    logic [5:0] pr;
  } mlb_bases_type;

  typedef struct packed {
    mlb_op_type op;
    logic qual_pred;
    mlb_strategy_type strategy;
    logic many_lines;
    logic deallocate;
    logic has_history;
    logic history_taken;
  } mlb_request_type;

  typedef struct packed {
    logic valid;
    logic taken;
    logic exit_loop;
    logic rotated;
    logic stage_we;
    logic stage_value;
  } mlb_result_type;

  typedef struct packed {
    logic valid;
    logic predict_taken;
    logic use_dynamic;
    logic allocate;
    logic release_entry;
    logic [3:0] prefetch_lines;
  } mlb_predict_type;

endpackage
`default_nettype wire

// >>> verilog/mlb_hint_unit.sv
// branch hint interpretation: prediction strategy, prefetch amount, entry release
`timescale 1ns/1ps
`default_nettype none
module mlb_hint_unit
  import mlb_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic valid,
  input wire mlb_strategy_type strategy,
  input wire logic many_lines,
  input wire logic deallocate,
  input wire logic has_history,
  input wire logic history_taken,
  input wire logic is_loop,
  input wire logic loop_taken,
  input wire logic [3:0] few_cfg,
  input wire logic [3:0] many_cfg,
  output mlb_predict_type predict
);

  mlb_predict_type next_predict;

  always_comb begin
    next_predict = '0;
    next_predict.valid = valid;
    next_predict.prefetch_lines = many_lines ? many_cfg : few_cfg;
    if (is_loop) begin
      // strategy hint ignored, counts or the qualifying predicate already tell the direction
      next_predict.predict_taken = loop_taken;
    end else begin
      case (strategy)
        MLB_STATIC_NOT_TAKEN: next_predict.predict_taken = 1'b0;
        MLB_STATIC_TAKEN: next_predict.predict_taken = 1'b1;
        MLB_DYNAMIC_NOT_TAKEN: begin
          next_predict.use_dynamic = 1'b1;
          next_predict.allocate = 1'b1;
          next_predict.predict_taken = has_history & history_taken;
        end
        MLB_DYNAMIC_TAKEN: begin
          next_predict.use_dynamic = 1'b1;
          next_predict.allocate = 1'b1;
          next_predict.predict_taken = ~has_history | history_taken;
        end
        default: next_predict.predict_taken = 1'b0;
      endcase
    end
    if (deallocate) begin
      next_predict.allocate = 1'b0;
      next_predict.release_entry = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      predict <= '0;
    end else begin
      predict <= next_predict;
    end
  end

endmodule // mlb_hint_unit
`default_nettype wire

// >>> verilog/mlb_loop_branch.sv
// loop branch resolution, counters, rotating bases and register slave
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`include "mlb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mlb_loop_branch
  import mlb_pkg::*;
#(
  parameter int LC_W = 32,
  parameter int EC_W = 6
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic req_valid,
  input wire mlb_request_type req,
  output mlb_result_type result,
  output mlb_predict_type predict,
  output mlb_bases_type bases
);

  logic [LC_W-1:0] loop_count;
  logic [EC_W-1:0] epilog_count;
  mlb_bases_type prev_bases;
  logic [6:0] gr_rot_size;
  logic [3:0] few_lines;
  logic [3:0] many_lines;
  logic bus_wr;

  logic is_counted;
  logic is_while;
  logic is_loop;
  logic is_top;
  logic cont;
  logic rotate;
  logic stage;
  logic dec_lc;
  logic dec_ec;
  logic taken;
  mlb_bases_type next_bases;

  // modulo decrement shared by the three rotating bases
  function automatic logic [6:0] dec_mod(input logic [6:0] base, input logic [6:0] size);
    dec_mod = (base == 7'h00) ? size - 7'h01 : base - 7'h01;
  endfunction

  function automatic logic [31:0] pack_bases(input mlb_bases_type b);
    pack_bases = '0;
    pack_bases[`MLB_GR_LSB +: 7] = b.gr;
    pack_bases[`MLB_FR_LSB +: 7] = b.fr;
    pack_bases[`MLB_PR_LSB +: 6] = b.pr;
  endfunction

  function automatic mlb_bases_type unpack_bases(input logic [31:0] w);
    unpack_bases.gr = w[`MLB_GR_LSB +: 7];
    unpack_bases.fr = w[`MLB_FR_LSB +: 7];
    unpack_bases.pr = w[`MLB_PR_LSB +: 6];
  endfunction

  // ---- bus slave: one wait cycle, answer at the second edge ----
  assign bus_wr = avs_write & ~avs_waitrequest;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      case (avs_address)
        `MLB_OFF_LOOP_COUNT: avs_readdata <= 32'(loop_count);
        `MLB_OFF_EPILOG_COUNT: avs_readdata <= 32'(epilog_count);
        `MLB_OFF_ROT_BASES: avs_readdata <= pack_bases(bases);
        `MLB_OFF_PREV_BASES: avs_readdata <= pack_bases(prev_bases);
        `MLB_OFF_GR_ROT_SIZE: avs_readdata <= 32'(gr_rot_size);
        `MLB_OFF_PREFETCH: avs_readdata <= {20'h0_0000, many_lines, 4'h0, few_lines};
        `MLB_OFF_STATUS: avs_readdata <= {28'h000_0000, result.stage_value, result.rotated,
                                          result.exit_loop, result.taken};
        default: avs_readdata <= `MLB_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gr_rot_size <= `MLB_GR_SIZE_RST;
      few_lines <= `MLB_FEW_LINES_RST;
      many_lines <= `MLB_MANY_LINES_RST;
    end else if (bus_wr) begin
      if (avs_address == `MLB_OFF_GR_ROT_SIZE) begin
        gr_rot_size <= avs_writedata[6:0];
      end
      if (avs_address == `MLB_OFF_PREFETCH) begin
        few_lines <= avs_writedata[3:0];
        many_lines <= avs_writedata[`MLB_MANY_LSB +: 4];
      end
    end
  end

  // ---- branch resolution ----
  assign is_counted = req_valid & ((req.op == MLB_OP_COUNTED_TOP) | (req.op == MLB_OP_COUNTED_EXIT));
  assign is_while = req_valid & ((req.op == MLB_OP_WHILE_TOP) | (req.op == MLB_OP_WHILE_EXIT));
  assign is_loop = is_counted | is_while;
  assign is_top = (req.op == MLB_OP_COUNTED_TOP) | (req.op == MLB_OP_WHILE_TOP);

  // hints never enter this path, so they cannot alter results
  always_comb begin
    cont = 1'b0;
    rotate = 1'b0;
    stage = 1'b0;
    dec_lc = 1'b0;
    dec_ec = 1'b0;
    if (is_counted) begin
      // qualifying predicate deliberately unread here
      if (loop_count != '0) begin
        cont = 1'b1;
        dec_lc = 1'b1;
        rotate = 1'b1;
        stage = 1'b1;
      end else if (epilog_count > EC_W'(1)) begin
        cont = 1'b1;
        dec_ec = 1'b1;
        rotate = 1'b1;
      end else if (epilog_count == EC_W'(1)) begin
        dec_ec = 1'b1;
        rotate = 1'b1;
      end
      // both zero: exit with no rotation, stage stays zero
    end else if (is_while) begin
      // loop count neither read nor written
      if (req.qual_pred) begin
        cont = 1'b1;
        rotate = 1'b1;
      end else if (epilog_count > EC_W'(1)) begin
        cont = 1'b1;
        dec_ec = 1'b1;
        rotate = 1'b1;
      end else if (epilog_count == EC_W'(1)) begin
        dec_ec = 1'b1;
        rotate = 1'b1;
      end
      // zero predicate and zero epilog: exit, no change
    end
  end

  // top continues on taken, exit form continues on not-taken
  assign taken = is_top ? cont : ~cont;

  always_comb begin
    next_bases = bases;
    if (req_valid) begin
      case (req.op)
        MLB_OP_CLEAR_ALL, MLB_OP_CALL: next_bases = '0;
        MLB_OP_CLEAR_PRED: next_bases.pr = 6'h00;
        MLB_OP_RETURN: next_bases = prev_bases;
        default: begin
          if (rotate) begin
            if (gr_rot_size != 7'h00) begin
              next_bases.gr = dec_mod(bases.gr, gr_rot_size);
            end
            next_bases.fr = dec_mod(bases.fr, `MLB_FR_ROT_SIZE);
            next_bases.pr = 6'(dec_mod({1'b0, bases.pr}, `MLB_PR_ROT_SIZE));
          end
        end
      endcase
    end
  end

  // a bus write in the same cycle overrides the branch update
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      loop_count <= '0;
    end else if (bus_wr && avs_address == `MLB_OFF_LOOP_COUNT) begin
      loop_count <= avs_writedata[LC_W-1:0];
    end else if (dec_lc) begin
      loop_count <= loop_count - LC_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      epilog_count <= '0;
    end else if (bus_wr && avs_address == `MLB_OFF_EPILOG_COUNT) begin
      epilog_count <= avs_writedata[EC_W-1:0];
    end else if (dec_ec) begin
      epilog_count <= epilog_count - EC_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bases <= `MLB_BASES_RST;
    end else if (bus_wr && avs_address == `MLB_OFF_ROT_BASES) begin
      bases <= unpack_bases(avs_writedata);
    end else begin
      bases <= next_bases;
    end
  end

  // a call saves the live bases so that a later return can restore them
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_bases <= `MLB_BASES_RST;
    end else if (bus_wr && avs_address == `MLB_OFF_PREV_BASES) begin
      prev_bases <= unpack_bases(avs_writedata);
    end else if (req_valid && req.op == MLB_OP_CALL) begin
      prev_bases <= bases;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      result <= '0;
    end else begin
      result.valid <= is_loop;
      result.stage_we <= is_loop;
      // outcome fields hold the last loop branch so the status word stays readable
      if (is_loop) begin
        result.taken <= taken;
        result.exit_loop <= ~cont;
        result.rotated <= rotate;
        result.stage_value <= stage;
      end
    end
  end

  mlb_hint_unit u_hint (
    .clock(clock),
    .nrst(nrst),
    .valid(req_valid),
    .strategy(req.strategy),
    .many_lines(req.many_lines),
    .deallocate(req.deallocate),
    .has_history(req.has_history),
    .history_taken(req.history_taken),
    .is_loop(is_loop),
    .loop_taken(taken),
    .few_cfg(few_lines),
    .many_cfg(many_lines),
    .predict(predict)
  );

  // ---- checks ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic top_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      top_q <= 1'b0;
    end else begin
      top_q <= is_top;
    end
  end

  a_top_direction: assert property (
    result.valid && top_q |-> result.taken == !result.exit_loop)
    else $error("top form direction wrong");

  a_exit_direction: assert property (
    result.valid && !top_q |-> result.taken == result.exit_loop)
    else $error("exit form direction wrong");

  a_lc_decrement: assert property (
    is_counted && loop_count != '0 && !bus_wr
    |=> loop_count == $past(loop_count) - LC_W'(1) && result.stage_value && !result.exit_loop)
    else $error("loop count not decremented with stage one");

  a_both_zero_hold: assert property (
    is_counted && loop_count == '0 && epilog_count == '0 && !bus_wr
    |=> result.exit_loop && !result.rotated && !result.stage_value && $stable(bases)
        && epilog_count == '0)
    else $error("both-zero counted branch changed state");

  a_epilog_last: assert property (
    is_counted && loop_count == '0 && epilog_count == EC_W'(1) && !bus_wr
    |=> epilog_count == '0 && result.exit_loop && result.rotated && !result.stage_value)
    else $error("last epilog stage mishandled");

  a_while_kernel: assert property (
    is_while && req.qual_pred && !bus_wr
    |=> $stable(epilog_count) && $stable(loop_count) && result.rotated && !result.exit_loop
        && !result.stage_value)
    else $error("while kernel step wrong");

  a_fr_rotation: assert property (
    is_loop && rotate && !bus_wr
    |=> bases.fr == (($past(bases.fr) == 7'h00) ? 7'h5f : $past(bases.fr) - 7'h01))
    else $error("float base not decremented modulo region");

  a_gr_frozen: assert property (
    is_loop && rotate && gr_rot_size == 7'h00 && !bus_wr |=> $stable(bases.gr))
    else $error("general base rotated with empty region");

  a_clear_all: assert property (
    req_valid && (req.op == MLB_OP_CLEAR_ALL || req.op == MLB_OP_CALL) && !bus_wr
    |=> bases == '0)
    else $error("bases not cleared");

  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle later");

endmodule // mlb_loop_branch
`default_nettype wire

// >>> tb/mlb_decode_model.sv
// decode-side model that hands one branch or base instruction at a time to the loop branch unit
`timescale 1ns/1ps
`default_nettype none
module mlb_decode_model
  import mlb_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic go,
  input wire mlb_request_type cmd,
  output logic req_valid,
  output mlb_request_type req
);
  logic [$bits(mlb_request_type)-1:0] idle_pat;

  // between instructions the fields churn, so nothing may be read from them unqualified
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_pat <= '1;
    end else begin
      idle_pat <= ~idle_pat;
    end
  end

  // at most one instruction per cycle, qualified by the valid strobe
  assign req_valid = go;
  assign req = go ? cmd : mlb_request_type'(idle_pat);
endmodule // mlb_decode_model
`default_nettype wire

// >>> tb/mlb_loop_branch_tb_top.sv
// self-checking bench for the loop branch unit: bus access, loop branches, base ops, hints
`include "mlb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mlb_loop_branch_tb_top
  import mlb_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic go = 1'b0;
  mlb_request_type cmd = '0;
  logic req_valid;
  mlb_request_type req;
  mlb_result_type result;
  mlb_predict_type predict;
  mlb_bases_type bases;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] lc = 32'h0000_0000;
  logic [5:0] ec = 6'h00;
  logic [6:0] grsz = 7'h00;
  mlb_bases_type cur = '0;
  mlb_bases_type prv = '0;
  logic [31:0] d;

  always #25 clock = ~clock;

  mlb_decode_model u_partner (.clock(clock), .nrst(nrst), .go(go), .cmd(cmd),
    .req_valid(req_valid), .req(req));

  mlb_loop_branch u_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
    .req(req), .result(result), .predict(predict), .bases(bases));

  task give_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hung handshake ends the run here
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task check1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask

  task checkw(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // waitrequest is read before the edge's updates land, so it is the value sampled there
  task bus_write(input logic [4:0] a, input logic [31:0] v);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task bus_read(input logic [4:0] a, output logic [31:0] v);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task load(input logic [31:0] lv, input logic [5:0] ev);
    bus_write(`MLB_OFF_LOOP_COUNT, lv);
    bus_write(`MLB_OFF_EPILOG_COUNT, {26'h000_0000, ev});
    lc = lv;
    ec = ev;
  endtask

  // h holds many_lines, deallocate, has_history, history_taken
  task automatic branch(input mlb_op_type op, input logic q, input mlb_strategy_type st,
                        input logic [3:0] h);
    logic cnt, lp, cont, rot, stg, tk, pt;
    cnt = op == MLB_OP_COUNTED_TOP || op == MLB_OP_COUNTED_EXIT;
    lp = cnt || op == MLB_OP_WHILE_TOP || op == MLB_OP_WHILE_EXIT;
    cont = 1'b0;
    rot = 1'b0;
    stg = 1'b0;
    if (lp) begin
      if (cnt && lc != 32'h0000_0000) begin
        cont = 1'b1;
        rot = 1'b1;
        stg = 1'b1;
        lc = lc - 32'h0000_0001;
      end else if (!cnt && q) begin
        cont = 1'b1;
        rot = 1'b1;
      end else if (ec != 6'h00) begin
        cont = ec != 6'h01;
        rot = 1'b1;
        ec = ec - 6'h01;
      end
    end
    if (rot) begin
      if (grsz != 7'h00) cur.gr = (cur.gr == 7'h00) ? grsz - 7'h01 : cur.gr - 7'h01;
      cur.fr = (cur.fr == 7'h00) ? 7'h5f : cur.fr - 7'h01;
      cur.pr = (cur.pr == 6'h00) ? 6'h2f : cur.pr - 6'h01;
    end
    case (op)
      MLB_OP_CLEAR_ALL: cur = '0;
      MLB_OP_CLEAR_PRED: cur.pr = 6'h00;
      MLB_OP_CALL: begin
        prv = cur;
        cur = '0;
      end
      MLB_OP_RETURN: cur = prv;
      default: ;
    endcase
    tk = (op == MLB_OP_COUNTED_TOP || op == MLB_OP_WHILE_TOP) ? cont : !cont;
    pt = (st == MLB_STATIC_TAKEN) || (st == MLB_DYNAMIC_TAKEN && !h[1]) ||
         (st != MLB_STATIC_TAKEN && st != MLB_STATIC_NOT_TAKEN && h[1] && h[0]);
    @(posedge clock);
    go <= 1'b1;
    cmd <= '{op, q, st, h[3], h[2], h[1], h[0]};
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    check1("result valid", lp, result.valid);
    checkw("bases", {12'h000, cur}, {12'h000, bases});
    check1("predict valid", 1'b1, predict.valid);
    checkw("prefetch", {28'h000_0000, h[3] ? 4'h8 : 4'h2}, {28'h000_0000, predict.prefetch_lines});
    if (lp) begin
      check1("taken", tk, result.taken);
      check1("exit", !cont, result.exit_loop);
      check1("rotated", rot, result.rotated);
      check1("stage write", 1'b1, result.stage_we);
      check1("stage value", stg, result.stage_value);
      check1("loop predict", tk, predict.predict_taken);
      bus_read(`MLB_OFF_LOOP_COUNT, d);
      checkw("loop count", lc, d);
      bus_read(`MLB_OFF_EPILOG_COUNT, d);
      checkw("epilog count", {26'h000_0000, ec}, d);
    end else begin
      check1("predict", pt, predict.predict_taken);
      check1("dynamic", st == MLB_DYNAMIC_TAKEN || st == MLB_DYNAMIC_NOT_TAKEN, predict.use_dynamic);
      check1("allocate", (st == MLB_DYNAMIC_TAKEN || st == MLB_DYNAMIC_NOT_TAKEN) && !h[2], predict.allocate);
      check1("release", h[2], predict.release_entry);
    end
  endtask

  mlb_op_type ops[8] = '{MLB_OP_CALL, MLB_OP_COUNTED_TOP, MLB_OP_WHILE_TOP, MLB_OP_CLEAR_PRED,
                         MLB_OP_CALL, MLB_OP_RETURN, MLB_OP_CLEAR_ALL, MLB_OP_RETURN};
  mlb_strategy_type sts[4] = '{MLB_STATIC_NOT_TAKEN, MLB_STATIC_TAKEN, MLB_DYNAMIC_NOT_TAKEN,
                               MLB_DYNAMIC_TAKEN};
  logic [2:0] k;

  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus_read(5'(i * 4), d);
      checkw("reset reg", (i == 5) ? 32'h0000_0802 : 32'h0000_0000, d);
    end
    load(32'h0000_0002, 6'h03);
    for (int i = 0; i < 6; i++) begin
      branch(MLB_OP_COUNTED_TOP, i[0], MLB_STATIC_TAKEN, 4'h0);
    end
    bus_read(`MLB_OFF_STATUS, d);
    checkw("status", 32'h0000_0002, d);
    bus_write(`MLB_OFF_GR_ROT_SIZE, 32'h0000_0008);
    grsz = 7'h08;
    load(32'h0000_0001, 6'h02);
    for (int i = 0; i < 4; i++) begin
      branch(MLB_OP_COUNTED_EXIT, !i[0], MLB_DYNAMIC_TAKEN, 4'h0);
    end
    for (int j = 0; j < 2; j++) begin
      load(32'h0000_0005, 6'h02);
      for (int i = 0; i < 4; i++) begin
        branch(j == 0 ? MLB_OP_WHILE_TOP : MLB_OP_WHILE_EXIT, i == 0, MLB_STATIC_NOT_TAKEN, 4'h0);
      end
    end
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      branch(ops[i], 1'b1, sts[i % 4], {k[0], k[1], k[2], k[0]});
    end
    give_verdict();
  end
endmodule // mlb_loop_branch_tb_top
`default_nettype wire
